// [src/nptx_defines.svh]
// constants of the nibble payload transmit interface
`ifndef NPTX_DEFINES_SVH
`define NPTX_DEFINES_SVH

// clock and nibble timing
`define NPTX_CLK_PERIOD_NS 8
`define NPTX_REF_FREQ_KHZ 44736
`define NPTX_NIB_FREQ_KHZ 11184
`define NPTX_DIV (`NPTX_REF_FREQ_KHZ / `NPTX_NIB_FREQ_KHZ)
`define NPTX_LONG_SLOT 5
`define NPTX_SAMPLE_EDGE 3

// frame structure
`define NPTX_BITS_PER_FRAME 4704
`define NPTX_NIB_PER_FRAME (`NPTX_BITS_PER_FRAME / 4)
`define NPTX_LONG_GAPS 14
`define NPTX_GROUP (`NPTX_NIB_PER_FRAME / `NPTX_LONG_GAPS)

// buffer shape
`define NPTX_FIFO_DEPTH 32
`define NPTX_FIFO_WIDTH 5

// register offsets
`define NPTX_ADDR_MODE 8'h00
`define NPTX_ADDR_STATUS 8'h01
`define NPTX_ADDR_IDX_LO 8'h02
`define NPTX_ADDR_IDX_HI 8'h03
`define NPTX_ADDR_LEVEL 8'h04

// operating mode fields and reset value
`define NPTX_MODE_LOOPBACK 7
`define NPTX_MODE_DS3_SEL 6
`define NPTX_MODE_LOS_EN 5
`define NPTX_MODE_SOFT_RST 4
`define NPTX_MODE_INT_EN_RST 3
`define NPTX_MODE_FRAME_FMT 2
`define NPTX_MODE_TIMSEL_HI 1
`define NPTX_MODE_TIMSEL_LO 0
`define NPTX_MODE_RESET 8'h00
`define NPTX_TIMSEL_SLAVE 2'h1

`endif

// [src/nptx_pkg.sv]
// types and shared decoding of the nibble payload transmit interface
`include "nptx_defines.svh"

package nptx_pkg;

    // framing mode of the transmit side
    typedef enum logic [1:0] {
        NPTX_IDLE   = 2'b00,
        NPTX_SLAVE  = 2'b01,
        NPTX_MASTER = 2'b10
    } nptx_mode_e;

    typedef logic [10:0] nptx_idx_t;

    // true for the final payload nibble of a frame
    function automatic logic nptx_is_last(input nptx_idx_t idx);
        return idx == 11'(`NPTX_NIB_PER_FRAME - 1);
    endfunction : nptx_is_last

endpackage : nptx_pkg

// [src/nptx_if.sv]
// carriers between the transmit interface top, its buffer and its slot timer
`timescale 1ns/10ps

interface nptx_stream_if #(parameter int WIDTH = 5, parameter int LW = 6);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;
    logic [LW-1:0] level;
    modport wr_m (output data, output valid, input ready, input level);
    modport wr_s (input data, input valid, output ready, output level);
    modport rd_s (output data, output valid, input ready);
    modport rd_m (input data, input valid, output ready);
endinterface : nptx_stream_if

interface nptx_slot_if;
    logic run;
    logic hold;
    logic resync;
    logic [2:0] phase;
    logic [10:0] idx;
    modport gen (input run, input hold, input resync, output phase, output idx);
    modport user (output run, output hold, output resync, input phase, input idx);
endinterface : nptx_slot_if

// [src/nptx_fifo.sv]
// payload buffer between the nibble sampler and the transmit path
`timescale 1ns/10ps

module nptx_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic flush_i,
    nptx_stream_if.wr_s in_if,
    nptx_stream_if.rd_s out_if
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    // handshakes and flags
    assign in_if.ready = count_ff != (AW+1)'(DEPTH);
    assign in_if.level = count_ff;
    assign out_if.valid = count_ff != '0;
    assign out_if.data = mem_ff[rd_ptr_ff];
    assign push = in_if.valid && in_if.ready;
    assign pop = out_if.valid && out_if.ready;

    // storage, written at the write index
    always_ff @(posedge clk_i) begin
        if (ce_i && push) begin
            mem_ff[wr_ptr_ff] <= in_if.data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else if (ce_i) begin
            if (flush_i) begin
                wr_ptr_ff <= '0;
                rd_ptr_ff <= '0;
                count_ff <= '0;
            end else begin
                if (push) begin
                    wr_ptr_ff <= wr_ptr_ff + 1'b1;
                end
                if (pop) begin
                    rd_ptr_ff <= rd_ptr_ff + 1'b1;
                end
                if (push && !pop) begin
                    count_ff <= count_ff + 1'b1;
                end else if (pop && !push) begin
                    count_ff <= count_ff - 1'b1;
                end
            end
        end
    end

endmodule : nptx_fifo

// [src/nptx_slot_gen.sv]
// nibble slot timer: reference cycles per slot and nibble index in the frame
`timescale 1ns/10ps

module nptx_slot_gen
    import nptx_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    nptx_slot_if.gen slot
);
    logic [2:0] phase_ff;
    nptx_idx_t idx_ff;
    logic [6:0] grp_ff;
    logic [2:0] last_phase;
    logic slot_end;

    assign slot.phase = phase_ff;
    assign slot.idx = idx_ff;

    // one slot in each group of nibbles is a cycle longer
    assign last_phase = (grp_ff == 7'(`NPTX_GROUP - 1)) ? 3'(`NPTX_LONG_SLOT - 1)
                                                        : 3'(`NPTX_DIV - 1); // see [R4] [R15]
    assign slot_end = phase_ff == last_phase;

    // phase within the slot; a buffer one entry short of full stalls before the clock pulse
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_ff <= '0;
        end else if (ce_i) begin
            if (!slot.run) begin
                phase_ff <= '0;
            end else if (phase_ff == '0 && slot.hold) begin
                phase_ff <= '0;
            end else if (slot_end) begin
                phase_ff <= '0;
            end else begin
                phase_ff <= phase_ff + 1'b1; // see [R2]
            end
        end
    end

    // nibble index and group position, restarted by the frame reference
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            idx_ff <= '0;
            grp_ff <= '0;
        end else if (ce_i) begin
            if (!slot.run) begin
                idx_ff <= '0;
                grp_ff <= '0;
            end else if (slot.resync) begin
                idx_ff <= 11'h001; // see [R9]
                grp_ff <= 7'h01;
            end else if (slot_end) begin
                idx_ff <= nptx_is_last(idx_ff) ? '0 : idx_ff + 1'b1; // see [R3]
                grp_ff <= (grp_ff == 7'(`NPTX_GROUP - 1)) ? '0 : grp_ff + 1'b1;
            end
        end
    end

endmodule : nptx_slot_gen

// [src/nptx_top.sv]
// nibble-parallel payload transmit interface of one framer channel
//
// What this block does
// [R1] payload nibble sampled on third reference edge after each nibble clock rise
// [R2] reference clock divided by four drives the nibble clock output
// [R3] exactly 1176 nibble clock pulses per frame, one per payload nibble
// [R4] slots are 4 reference periods, 14 per frame are 5 periods
// [R5] only payload nibbles cross this port, never overhead positions
// [R6] payload lines captured in the slot opened by the nibble clock rise
// [R7] terminal drives each nibble on the nibble clock rising edge
// [R8] terminal pulses frame reference for one period with first nibble
// [R9] in frame-slave mode a frame reference rising edge restarts the frame
// [R10] in frame-master mode frames run freely from the reference clock
// [R11] in frame-master mode boundary output high during the last nibble
// [R12] overhead indicator held low while nibble modes run
// [R13] nibble select pin high; timing select 01 slave, 1x master
// [R14] operating mode register at 0x00 with its seven read-write fields
// [R15] long slots spread evenly, one per 84 nibbles
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps

module nptx_top
    import nptx_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic nibble_interface_select_i,
    input wire logic [3:0] tx_payload_nibble_in_i,
    input wire logic frame_reference_in_i,
    output logic nibble_clock_out_o,
    output logic frame_boundary_out_o,
    output logic overhead_indicator_o,
    output logic [3:0] tx_data_o,
    output logic tx_first_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i
);
    localparam int LW = $clog2(`NPTX_FIFO_DEPTH) + 1;

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [7:0] mode_reg_ff;
    logic [7:0] rd_data_ff;
    nptx_mode_e mode_ff;
    nptx_mode_e nxt_mode;
    logic sel_s1_ff;
    logic sel_s2_ff;
    logic [3:0] nib_s1_ff;
    logic [3:0] nib_s2_ff;
    logic ref_s1_ff;
    logic ref_s2_ff;
    logic ref_prev_ff;
    logic smp1_ff;
    logic smp2_ff;
    logic first1_ff;
    logic first2_ff;
    logic nib_clk_ff;
    logic boundary_ff;
    logic ovh_ind_ff;
    logic [3:0] out_data_ff;
    logic out_first_ff;
    logic out_valid_ff;
    logic run;
    logic soft_rst;
    logic push_first;
    logic take_out;
    logic [1:0] timsel;

    nptx_stream_if #(.WIDTH(`NPTX_FIFO_WIDTH), .LW(LW)) wr_bus ();
    nptx_stream_if #(.WIDTH(`NPTX_FIFO_WIDTH), .LW(LW)) rd_bus ();
    nptx_slot_if slot_bus ();

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers, two stages each

    // the first stage feeds only the second
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_s1_ff <= 1'b0;
            sel_s2_ff <= 1'b0;
        end else if (ce_i) begin
            sel_s1_ff <= nibble_interface_select_i;
            sel_s2_ff <= sel_s1_ff;
        end
    end

    // payload lines, first stage taken every reference edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            nib_s1_ff <= 4'h0;
            nib_s2_ff <= 4'h0;
        end else if (ce_i) begin
            nib_s1_ff <= tx_payload_nibble_in_i;
            nib_s2_ff <= nib_s1_ff;
        end
    end

    // frame reference input, aligned with the payload lines
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ref_s1_ff <= 1'b0;
            ref_s2_ff <= 1'b0;
        end else if (ce_i) begin
            ref_s1_ff <= frame_reference_in_i;
            ref_s2_ff <= ref_s1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // operating mode register and mode selection

    assign timsel = mode_reg_ff[`NPTX_MODE_TIMSEL_HI:`NPTX_MODE_TIMSEL_LO];
    assign soft_rst = mode_reg_ff[`NPTX_MODE_SOFT_RST];

    // all eight bits are read-write storage
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_reg_ff <= `NPTX_MODE_RESET;
        end else if (ce_i && reg_wr_i && reg_addr_i == `NPTX_ADDR_MODE) begin
            mode_reg_ff <= reg_wdata_i; // see [R14]
        end
    end

    // nibble select pin and timing select pick the framing mode
    always_comb begin
        nxt_mode = NPTX_IDLE;
        if (sel_s2_ff && !soft_rst) begin
            case (timsel)
                `NPTX_TIMSEL_SLAVE: nxt_mode = NPTX_SLAVE; // see [R13]
                2'b10: nxt_mode = NPTX_MASTER; // see [R13]
                2'b11: nxt_mode = NPTX_MASTER; // low bit ignored, see [R13]
                default: nxt_mode = NPTX_IDLE;
            endcase
        end
    end

    // mode state
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_ff <= NPTX_IDLE;
        end else if (ce_i) begin
            mode_ff <= nxt_mode;
        end
    end

    // the slot timer runs in either local-timed nibble mode
    always_comb begin
        case (mode_ff)
            NPTX_SLAVE: run = 1'b1;
            NPTX_MASTER: run = 1'b1; // see [R10]
            default: run = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // slot timer

    assign slot_bus.run = run;
    // stall before the clock pulse while a pending nibble could overflow the buffer
    assign slot_bus.hold = wr_bus.level >= LW'(`NPTX_FIFO_DEPTH - 1);
    // a rising frame reference marks the nibble just pushed as nibble zero
    assign slot_bus.resync = mode_ff == NPTX_SLAVE && wr_bus.valid && push_first; // see [R9]

    nptx_slot_gen u_slot (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .slot(slot_bus)
    );

    // nibble clock high for the first two reference periods of each slot
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            nib_clk_ff <= 1'b0;
        end else if (ce_i) begin
            nib_clk_ff <= run && !(slot_bus.phase == 3'h0 && slot_bus.hold)
                          && slot_bus.phase <= 3'h1 && slot_bus.phase != 3'h1
                          || run && slot_bus.phase == 3'h1; // see [R2] [R3]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sampling pipeline

    // strobe at the third reference edge after the nibble clock rise
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            smp1_ff <= 1'b0;
            smp2_ff <= 1'b0;
            first1_ff <= 1'b0;
            first2_ff <= 1'b0;
        end else if (ce_i) begin
            smp1_ff <= run && slot_bus.phase == 3'(`NPTX_SAMPLE_EDGE); // see [R1] [R6]
            smp2_ff <= run && smp1_ff;
            first1_ff <= slot_bus.idx == '0;
            first2_ff <= first1_ff;
        end
    end

    // nibble zero comes from the own count in master mode, from the reference in slave
    always_comb begin
        case (mode_ff)
            NPTX_SLAVE: push_first = ref_s2_ff && !ref_prev_ff; // see [R9]
            NPTX_MASTER: push_first = first2_ff; // see [R10]
            default: push_first = 1'b0;
        endcase
    end

    // reference level remembered at each sample for edge detection
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ref_prev_ff <= 1'b0;
        end else if (ce_i && smp2_ff) begin
            ref_prev_ff <= ref_s2_ff;
        end
    end

    // only payload nibbles enter the buffer
    assign wr_bus.valid = smp2_ff; // see [R5]
    assign wr_bus.data = {push_first, nib_s2_ff};

    ////////////////////////////////////////////////////////////////////////////
    // payload buffer and output stage

    nptx_fifo #(
        .WIDTH(`NPTX_FIFO_WIDTH),
        .DEPTH(`NPTX_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .flush_i(soft_rst),
        .in_if(wr_bus),
        .out_if(rd_bus)
    );

    assign take_out = !out_valid_ff || tx_ready_i;
    assign rd_bus.ready = take_out;

    // register stage toward the transmit path
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_valid_ff <= 1'b0;
            out_data_ff <= 4'h0;
            out_first_ff <= 1'b0;
        end else if (ce_i) begin
            if (soft_rst) begin
                out_valid_ff <= 1'b0;
            end else if (take_out) begin
                out_valid_ff <= rd_bus.valid;
                out_data_ff <= rd_bus.data[3:0];
                out_first_ff <= rd_bus.data[4];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame boundary and overhead indicator

    // boundary pulse spans the slot of the last nibble in master mode
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            boundary_ff <= 1'b0;
        end else if (ce_i) begin
            boundary_ff <= mode_ff == NPTX_MASTER && nptx_is_last(slot_bus.idx); // see [R11]
        end
    end

    // overhead is generated internally, so the indicator never rises
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ovh_ind_ff <= 1'b0;
        end else if (ce_i) begin
            ovh_ind_ff <= 1'b0; // see [R12]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read port, data valid the cycle after the strobe

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_ff <= 8'h00;
        end else if (ce_i) begin
            rd_data_ff <= 8'h00;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `NPTX_ADDR_MODE: rd_data_ff <= mode_reg_ff; // see [R14]
                    `NPTX_ADDR_STATUS: rd_data_ff <= {3'h0, sel_s2_ff, rd_bus.valid,
                                                      !wr_bus.ready, mode_ff};
                    `NPTX_ADDR_IDX_LO: rd_data_ff <= slot_bus.idx[7:0];
                    `NPTX_ADDR_IDX_HI: rd_data_ff <= {5'h00, slot_bus.idx[10:8]};
                    `NPTX_ADDR_LEVEL: rd_data_ff <= 8'(wr_bus.level);
                    default: rd_data_ff <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops

    assign reg_rdata_o = rd_data_ff;
    assign nibble_clock_out_o = nib_clk_ff;
    assign frame_boundary_out_o = boundary_ff;
    assign overhead_indicator_o = ovh_ind_ff;
    assign tx_data_o = out_data_ff;
    assign tx_first_o = out_first_ff;
    assign tx_valid_o = out_valid_ff;

endmodule : nptx_top

// [test/nptx_checker.sv]
// port assertions for the nibble payload transmit interface
`timescale 1ns/10ps

module nptx_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic nibble_interface_select_i,
    input wire logic nibble_clock_out_o,
    input wire logic frame_boundary_out_o,
    input wire logic overhead_indicator_o,
    input wire logic [3:0] tx_data_o,
    input wire logic tx_first_o,
    input wire logic tx_valid_o,
    input wire logic tx_ready_i
);
    logic [7:0] mode_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////
    // mode register as software wrote it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_ff <= 8'h00;
        end else if (reg_wr_i && reg_addr_i == 8'h00) begin
            mode_ff <= reg_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////
    // nibble clock and framing outputs
    AST_NCK_SHAPE: assert property ($rose(nibble_clock_out_o) |->
        nibble_clock_out_o[*2] ##1 !nibble_clock_out_o[*2])
        else $error("nibble clock shape");
    AST_PIN_IDLE: assert property (!nibble_interface_select_i[*5] |->
        !nibble_clock_out_o)
        else $error("clock with pin low");
    AST_SEL_IDLE: assert property (reg_wr_i && reg_addr_i == 8'h00 &&
        reg_wdata_i[1:0] == 2'h0 |-> ##5 !nibble_clock_out_o[*8])
        else $error("clock with select idle");
    AST_FB_WIDTH: assert property ($rose(frame_boundary_out_o) |->
        frame_boundary_out_o[*5])
        else $error("boundary too short");
    AST_OH_LOW: assert property (overhead_indicator_o == 1'h0)
        else $error("overhead high");
    AST_HOLD: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o &&
        $stable(tx_data_o) && $stable(tx_first_o))
        else $error("beat changed in stall");

    ////////////////////////////////////////////////////////////////
    // register port
    AST_RD_ZERO: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data not zero");
    AST_RD_MODE: assert property (reg_rd_i && reg_addr_i == 8'h00 |=>
        reg_rdata_o == $past(mode_ff))
        else $error("mode readback");
    AST_RD_UNMAP: assert property (reg_rd_i && reg_addr_i > 8'h04 |=>
        reg_rdata_o == 8'h00)
        else $error("unmapped read");
endmodule : nptx_checker

bind nptx_top nptx_checker nptx_checker_i (.*);

// [test/nptx_terminal.sv]
// terminal equipment model feeding payload nibbles to the device
`timescale 1ns/10ps

module nptx_terminal (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic nib_clk_i,
    input wire logic frame_cue_i,
    input wire logic slave_i,
    input wire logic jump_i,
    output logic [3:0] nibble_o,
    output logic frame_ref_o
);
    logic [10:0] idx_ff;
    logic [10:0] send_w;
    logic [7:0] cue_cnt_ff;
    logic [7:0] cue_seen_ff;
    logic cue_d_ff;

    // count start-of-frame cues raised by the device
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cue_cnt_ff <= 8'h00;
            cue_d_ff <= 1'h0;
        end else begin
            cue_d_ff <= frame_cue_i;
            if (frame_cue_i && !cue_d_ff) begin
                cue_cnt_ff <= cue_cnt_ff + 8'h01;
            end
        end
    end

    // a fresh cue or a forced restart sends nibble zero next
    assign send_w = (cue_cnt_ff != cue_seen_ff || jump_i) ? 11'h000 : idx_ff;

    // only payload nibbles, a new one on each nibble clock rise
    always_ff @(posedge nib_clk_i or posedge rst_i) begin
        if (rst_i) begin
            idx_ff <= 11'h000;
            cue_seen_ff <= 8'h00;
            nibble_o <= 4'h0;
            frame_ref_o <= 1'h0;
        end else begin
            cue_seen_ff <= cue_cnt_ff;
            nibble_o <= send_w[3:0];
            frame_ref_o <= slave_i && send_w == 11'h000;
            idx_ff <= (send_w == 11'h497) ? 11'h000 : send_w + 11'h001;
        end
    end
endmodule : nptx_terminal

// [test/testbench.sv]
// self-checking bench for the nibble payload transmit interface
`timescale 1ns/10ps

module testbench
    import nptx_pkg::*;
;
    typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} nptx_row_s;
    nptx_row_s rows [9] = '{'{1'h0, 8'h00, 8'h00, 8'h00}, '{1'h1, 8'h00, 8'hFC, 8'h00},
        '{1'h0, 8'h00, 8'h00, 8'hFC}, '{1'h1, 8'h01, 8'hFF, 8'h00},
        '{1'h0, 8'h00, 8'h00, 8'hFC}, '{1'h1, 8'h10, 8'h55, 8'h00},
        '{1'h0, 8'h10, 8'h00, 8'h00}, '{1'h1, 8'h00, 8'h03, 8'h00},
        '{1'h0, 8'h00, 8'h00, 8'h03}};
    logic clk_i, rst_i, reg_wr_i, reg_rd_i, sel, fref, nck, fb, oh, first, valid, ready;
    logic slave, jump, nck_d, fb_d, resync;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic [3:0] nib, tx_data_o;
    logic [10:0] exp_idx;
    int n_fail, check_count, cyc, gap, rises, longs, odd, resbad, res0, nfb, nfb0;
    int f_rises, f_longs, f_odd, f_resbad, rises_tot, n_first, r0;

    nptx_top nptx_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .nibble_interface_select_i(sel),
        .tx_payload_nibble_in_i(nib), .frame_reference_in_i(fref),
        .nibble_clock_out_o(nck), .frame_boundary_out_o(fb), .overhead_indicator_o(oh),
        .tx_data_o(tx_data_o), .tx_first_o(first), .tx_valid_o(valid), .tx_ready_i(ready));
    nptx_terminal nptx_terminal_i (.clk_i(clk_i), .rst_i(rst_i), .nib_clk_i(nck),
        .frame_cue_i(fb), .slave_i(slave), .jump_i(jump), .nibble_o(nib), .frame_ref_o(fref));

    ////////////////////////////////////////////////////////////////
    // comparison, register access and closing report
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (e !== g) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] e);
        @(posedge clk_i);
        reg_wr_i <= w;
        reg_rd_i <= !w;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'h0;
        reg_rd_i <= 1'h0;
        #1;
        if (!w) chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata_o});
    endtask : bus

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        clk_i = 1'h0;
        forever #4 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            $display("[ERR] run length expected below 30000 seen %0d", cyc);
            summarize();
        end
    end

    // nibble clock spacing per frame and payload stream order
    always @(posedge clk_i) begin
        gap++;
        if (fb && !fb_d) begin
            nfb++;
            {f_rises, f_longs, f_odd, f_resbad} = {rises, longs, odd, resbad};
            {rises, longs, odd, resbad} = {32'h0, 32'h0, 32'h0, 32'h0};
        end
        if (nck && !nck_d) begin
            rises++;
            rises_tot++;
            if (gap == 5) begin
                longs++;
                if (longs == 1) res0 = rises % 84;
                else if (rises % 84 != res0) resbad++;
            end else if (gap != 4) odd++;
            gap = 0;
        end
        nck_d = nck;
        fb_d = fb;
        if (rst_i) begin
            exp_idx = 11'h000;
            n_first = 0;
        end else if (valid && ready) begin
            if (resync && first) begin
                exp_idx = 11'h000;
                resync = 1'h0;
            end
            if (first) n_first++;
            chk("tx_first", 16'(exp_idx == 11'h000), 16'(first));
            chk("tx_data", 16'(exp_idx[3:0]), 16'(tx_data_o));
            exp_idx = (exp_idx == 11'h497) ? 11'h000 : exp_idx + 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {rst_i, reg_wr_i, reg_rd_i, sel, slave, jump, resync, ready} = 8'h81;
        {reg_addr_i, reg_wdata_i} = 16'h0000;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'h0;
        foreach (rows[i]) bus(rows[i].w, rows[i].a, rows[i].d, rows[i].e);
        bus(1'h1, 8'h00, 8'h00, 8'h00);
        // idle timing select, then master with pin low
        sel <= 1'h1;
        r0 = rises_tot;
        repeat (40) @(posedge clk_i);
        chk("idle_sel", 16'(r0), 16'(rises_tot));
        sel <= 1'h0;
        repeat (5) @(posedge clk_i);
        bus(1'h1, 8'h00, 8'h03, 8'h00);
        repeat (40) @(posedge clk_i);
        chk("idle_pin", 16'(r0), 16'(rises_tot));
        // free running master frames, low select bit ignored
        sel <= 1'h1;
        for (int i = 0; i < 12000 && nfb < 2; i++) @(posedge clk_i);
        chk("frame_nibbles", 16'h0498, 16'(f_rises));
        chk("long_gaps", 16'h000E, 16'(f_longs));
        chk("odd_gaps", 16'h0000, 16'(f_odd));
        chk("gap_spread", 16'h0000, 16'(f_resbad));
        // stalled transmit path stops the nibble clock
        ready <= 1'h0;
        repeat (200) @(posedge clk_i);
        r0 = rises_tot;
        repeat (60) @(posedge clk_i);
        chk("stall", 16'(r0), 16'(rises_tot));
        ready <= 1'h1;
        repeat (300) @(posedge clk_i);
        // slave framing after a second reset
        rst_i <= 1'h1;
        slave <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        nfb0 = nfb;
        bus(1'h1, 8'h00, 8'h01, 8'h00);
        for (int i = 0; i < 6000 && n_first < 2; i++) @(posedge clk_i);
        chk("slave_frames", 16'h0002, 16'(n_first));
        // terminal restarts its frame early
        repeat (200) @(posedge clk_i);
        resync = 1'h1;
        jump <= 1'h1;
        @(posedge nck);
        @(posedge clk_i);
        jump <= 1'h0;
        for (int i = 0; i < 300 && resync; i++) @(posedge clk_i);
        chk("restart", 16'h0000, 16'(resync));
        repeat (200) @(posedge clk_i);
        chk("slave_boundary", 16'(nfb0), 16'(nfb));
        summarize();
    end
endmodule : testbench
